// ### rtl/csp_serial_port.sv
// The address map and register access over APB are this design's own decisions.
module csp_serial_port #(
  parameter int CAL_FRAMES = csp_pkg::CAL_FRAMES,
  parameter logic [3:0] VERSION_CODE = 4'h5 // The value is arbitrary.
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic power_down_pin,
  input wire logic port_mode_sel_a,
  input wire logic port_mode_sel_b,
  input wire logic port_mode_sel_c,
  input wire logic subframe_sel_a,
  input wire logic subframe_sel_b,
  input wire logic master_select,
  input wire logic bit_clock_in,
  output logic bit_clock_out,
  output logic bit_clock_oe_n,
  input wire logic frame_sync_pulse_in,
  output logic frame_sync_pulse_out,
  output logic frame_sync_pulse_oe_n,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic serial_out_line_oe_n,
  input wire logic gp_input_one,
  input wire logic multifunction_pin_six,
  input wire logic multifunction_pin_three,
  output logic gp_output_one,
  output logic gp_output_one_oe_n,
  output logic multifunction_pin_five,
  output logic multifunction_pin_five_oe_n,
  input wire logic [15:0] adc_left,
  input wire logic [15:0] adc_right,
  input wire logic adc_clip_left,
  input wire logic adc_clip_right,
  output logic [15:0] dac_left,
  output logic [15:0] dac_right,
  output logic [15:0] control_field_a,
  output logic [15:0] control_field_b,
  output logic analog_mute,
  output logic soft_power_down,
  output logic calibrating,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  if (CAL_FRAMES < 1 || CAL_FRAMES > 255)
  begin : g_cal_frames_check
    $error("CAL_FRAMES must lie in 1..255.");
  end

  typedef struct packed {
    csp_pkg::csp_pwr_type pwr;
    logic [6:0] half_cnt;
    logic phase;
    logic sclk_q;
    logic [7:0] bit_idx;
    logic [63:0] rx_sh;
    logic [63:0] tx_sh;
    logic [15:0] dac_l;
    logic [15:0] dac_r;
    logic [15:0] ctl_a;
    logic [15:0] ctl_b;
    logic [1:0] gp_out;
    logic ctl_err;
    logic [7:0] idle_cnt;
    logic soft_pd;
    logic [15:0] frame_clks;
    logic [15:0] last_len;
    logic [7:0] cal_cnt;
    logic mute;
    logic sout;
    logic sout_oe_n;
    logic bclk;
    logic fs;
    logic clk_oe_n;
    logic [1:0] gpo;
    logic [1:0] gpo_oe_n;
    logic [1:0] bpf_reg;
    logic [31:0] prdata;
  } csp_state_type;

  localparam csp_state_type RESET_STATE = '{
    pwr: csp_pkg::PWR_ON,
    phase: 1'b1,
    bpf_reg: csp_pkg::CTRL_BPF_RESET,
    cal_cnt: 8'(CAL_FRAMES),
    default: '0
  };

  csp_state_type s;
  csp_state_type next_s;

  logic [2:0] mode;
  logic split;
  logic is_mult;
  logic is_i2s;
  logic is_std;
  logic is_test;
  logic master;
  logic run;
  logic [3:0] lbpf;
  logic [1:0] own_sub;
  logic [7:0] bpf_last;
  logic [6:0] half_len;
  logic [7:0] slow_lim;
  logic mid;
  logic start;
  logic [7:0] cur;
  logic [7:0] nidx;
  logic [63:0] w;
  logic [63:0] tx_word;
  logic [3:0] err;
  logic [2:0] gp_in;
  logic mf5_used;
  logic addr_ok;

  // Own sub-frame test shared by the receive and transmit paths.
  function automatic logic in_own_sub(input logic [7:0] idx, input logic [3:0] lb,
                                      input logic sp, input logic [1:0] k);
    logic [7:0] sub;
    logic [7:0] nsub;
    sub = sp ? (idx >> csp_pkg::SUB_LOG_SPLIT) : (idx >> csp_pkg::SUB_LOG_FULL);
    nsub = 8'((9'h001 << lb) >> (sp ? csp_pkg::SUB_LOG_SPLIT : csp_pkg::SUB_LOG_FULL));
    in_own_sub = (sub == {6'h00, k}) && ({6'h00, k} < nsub);
  endfunction

  function automatic logic [5:0] sub_pos(input logic [7:0] idx, input logic sp);
    sub_pos = idx[5:0] & {~sp, 5'h1F};
  endfunction

  always_comb
  begin
    mode = {port_mode_sel_c, port_mode_sel_b, port_mode_sel_a};
    split = port_mode_sel_c;
    is_mult = !split && mode == csp_pkg::MODE_MULT;
    is_i2s = !split && mode == csp_pkg::MODE_I2S;
    is_std = !split && mode == csp_pkg::MODE_STD;
    is_test = !split && mode == csp_pkg::MODE_TEST;
    master = is_i2s || (!is_test && master_select);
    run = !is_test && s.pwr == csp_pkg::PWR_ON;
    own_sub = {subframe_sel_b, subframe_sel_a};
    if (is_i2s)
    begin
      lbpf = csp_pkg::LOG_BPF_I2S;
    end
    else if (split)
    begin
      lbpf = (s.bpf_reg == 2'h3) ? csp_pkg::LOG_BPF_SPLIT_MAX
                                 : csp_pkg::LOG_BPF_MIN + {2'h0, s.bpf_reg};
    end
    else
    begin
      lbpf = (s.bpf_reg == 2'h0) ? csp_pkg::LOG_BPF_I2S
                                 : csp_pkg::LOG_BPF_MIN + {2'h0, s.bpf_reg};
    end
    bpf_last = 8'((9'h001 << lbpf) - 9'h001);
    // At 256 bits a bit lasts two clocks, which stretches the frame; the clock is the fast one.
    half_len = (lbpf >= csp_pkg::LOG_HALF_BIT_BASE) ? 7'h01
               : 7'(8'h01 << (csp_pkg::LOG_HALF_BIT_BASE - lbpf));
    slow_lim = 8'(csp_pkg::SLOW_MULT_NUM << (csp_pkg::LOG_SLOW_BASE - lbpf));
    if (is_mult)
    begin
      slow_lim = 8'((slow_lim + csp_pkg::MULT_FACTOR - 8'h01) / csp_pkg::MULT_FACTOR);
    end
    // Pin five is the second output in every mode that carries control fields.
    mf5_used = !split;
    gp_in[0] = gp_input_one;
    gp_in[1] = !split && multifunction_pin_six;
    gp_in[2] = (is_std || is_mult) && !master && multifunction_pin_three;
    err = s.soft_pd ? csp_pkg::ERR_SOFT_PD
          : (s.ctl_err ? csp_pkg::ERR_CTRL_IGNORED : csp_pkg::ERR_NONE);
    if (split)
    begin
      tx_word = {adc_left, adc_right, 32'h00000000};
    end
    else
    begin
      tx_word = {adc_left, 5'h00, s.cal_cnt == 8'h00 && !s.soft_pd, adc_clip_left,
                 adc_clip_right, err, VERSION_CODE, adc_right, 12'h000,
                 gp_in[0], gp_in[1], gp_in[2], 1'b0};
    end
    if (s.cal_cnt != 8'h00)
    begin
      tx_word[63:48] = 16'h0000;
      tx_word[31:16] = 16'h0000;
    end
    addr_ok = paddr == csp_pkg::CTRL_OFFSET || paddr == csp_pkg::STATUS_OFFSET;
  end

  always_comb
  begin
    next_s = s;
    mid = 1'b0;
    start = 1'b0;
    w = {s.rx_sh[62:0], serial_in_line};
    next_s.sclk_q = bit_clock_in;
    if (run && master)
    begin
      if (s.half_cnt == 7'h00)
      begin
        next_s.half_cnt = half_len - 7'h01;
        next_s.phase = !s.phase;
        mid = !s.phase;
        start = s.phase;
      end
      else
      begin
        next_s.half_cnt = s.half_cnt - 7'h01;
      end
    end
    else if (run)
    begin
      mid = s.sclk_q && !bit_clock_in;
      start = !s.sclk_q && bit_clock_in;
    end
    cur = (mid && !master && frame_sync_pulse_in) ? 8'h00 : s.bit_idx;
    nidx = (s.bit_idx >= bpf_last) ? 8'h00 : s.bit_idx + 8'h01;
    if (run && s.frame_clks != 16'hFFFF)
    begin
      next_s.frame_clks = s.frame_clks + 16'h0001;
    end
    if (mid)
    begin
      next_s.bit_idx = cur;
      if (in_own_sub(cur, lbpf, split, own_sub))
      begin
        next_s.rx_sh = w;
        if (sub_pos(cur, split) == (split ? 6'h1F : 6'h3F))
        begin
          if (split)
          begin
            next_s.dac_l = w[31:16];
            next_s.dac_r = w[15:0];
          end
          else
          begin
            next_s.dac_l = w[csp_pkg::W_DAC_L +: 16];
            next_s.dac_r = w[csp_pkg::W_DAC_R +: 16];
            next_s.ctl_err = w[csp_pkg::W_CTL_IGNORE];
            if (!w[csp_pkg::W_CTL_IGNORE])
            begin
              next_s.ctl_a = w[csp_pkg::W_CTL_A +: 16];
              next_s.ctl_b = w[15:0];
              next_s.gp_out = {w[csp_pkg::W_DO2], w[csp_pkg::W_DO1]};
            end
          end
        end
      end
    end
    if (start)
    begin
      next_s.bit_idx = nidx;
      if (nidx == 8'h00)
      begin
        next_s.frame_clks = 16'h0000;
        next_s.last_len = s.frame_clks;
        if (s.last_len != 16'h0000 && s.frame_clks != s.last_len)
        begin
          next_s.cal_cnt = 8'(CAL_FRAMES);
        end
        else if (s.cal_cnt != 8'h00)
        begin
          next_s.cal_cnt = s.cal_cnt - 8'h01;
        end
      end
      if (in_own_sub(nidx, lbpf, split, own_sub))
      begin
        next_s.sout_oe_n = 1'b0;
        if (sub_pos(nidx, split) == 6'h00)
        begin
          next_s.sout = tx_word[63];
          next_s.tx_sh = {tx_word[62:0], 1'b0};
        end
        else
        begin
          next_s.sout = s.tx_sh[63];
          next_s.tx_sh = {s.tx_sh[62:0], 1'b0};
        end
      end
      else
      begin
        next_s.sout = 1'b0;
        next_s.sout_oe_n = 1'b1;
      end
    end
    if (run && !master)
    begin
      if (mid)
      begin
        next_s.idle_cnt = 8'h00;
        if (s.idle_cnt < slow_lim)
        begin
          next_s.soft_pd = 1'b0;
        end
      end
      else if (s.idle_cnt != 8'hFF)
      begin
        next_s.idle_cnt = s.idle_cnt + 8'h01;
      end
      if (s.idle_cnt >= slow_lim)
      begin
        next_s.soft_pd = 1'b1;
      end
    end
    else
    begin
      next_s.idle_cnt = 8'h00;
      next_s.soft_pd = 1'b0;
    end
    case (s.pwr)
      csp_pkg::PWR_ON:
      begin
        if (!power_down_pin)
        begin
          next_s.pwr = csp_pkg::PWR_DRAIN;
        end
      end
      csp_pkg::PWR_DRAIN:
      begin
        next_s.pwr = csp_pkg::PWR_OFF;
      end
      csp_pkg::PWR_OFF:
      begin
        if (power_down_pin)
        begin
          next_s.pwr = csp_pkg::PWR_ON;
          next_s.cal_cnt = 8'(CAL_FRAMES);
        end
      end
      default:
      begin
        next_s.pwr = csp_pkg::PWR_DRAIN;
      end
    endcase
    // Soft power-down keeps the general pins alive; only hard power-down stops them.
    next_s.mute = next_s.ctl_a[csp_pkg::CTL_MUTE_BIT] || next_s.soft_pd
                  || next_s.cal_cnt != 8'h00 || next_s.pwr != csp_pkg::PWR_ON;
    case (next_s.pwr)
      csp_pkg::PWR_ON:
      begin
        next_s.bclk = master && (is_i2s ? next_s.phase : !next_s.phase);
        next_s.fs = master && next_s.bit_idx == 8'h00;
        next_s.clk_oe_n = !master;
        next_s.gpo = {mf5_used && next_s.gp_out[1], next_s.gp_out[0]};
        next_s.gpo_oe_n = {!mf5_used, 1'b0};
        if (is_test)
        begin
          next_s.sout = 1'b0;
          next_s.sout_oe_n = 1'b1;
        end
      end
      csp_pkg::PWR_DRAIN:
      begin
        next_s.sout = 1'b0;
        next_s.sout_oe_n = 1'b0;
        next_s.bclk = 1'b0;
        next_s.fs = 1'b0;
        next_s.clk_oe_n = 1'b0;
        next_s.gpo = 2'h0;
        next_s.gpo_oe_n = 2'h0;
      end
      default:
      begin
        next_s.sout = 1'b0;
        next_s.sout_oe_n = 1'b1;
        next_s.bclk = 1'b0;
        next_s.fs = 1'b0;
        next_s.clk_oe_n = 1'b1;
        next_s.gpo = 2'h0;
        next_s.gpo_oe_n = 2'h3;
      end
    endcase
    next_s.prdata = 32'h00000000;
    if (psel && !penable && !pwrite)
    begin
      if (paddr == csp_pkg::CTRL_OFFSET)
      begin
        next_s.prdata[csp_pkg::CTRL_BPF_LSB +: 2] = s.bpf_reg;
      end
      else if (paddr == csp_pkg::STATUS_OFFSET)
      begin
        next_s.prdata[csp_pkg::STATUS_ERR_LSB +: 4] = err;
        next_s.prdata[csp_pkg::STATUS_SOFT_PD_BIT] = s.soft_pd;
        next_s.prdata[csp_pkg::STATUS_CAL_BIT] = s.cal_cnt != 8'h00;
        next_s.prdata[csp_pkg::STATUS_MASTER_BIT] = master;
        next_s.prdata[csp_pkg::STATUS_PWR_LSB +: 2] = s.pwr;
        next_s.prdata[csp_pkg::STATUS_SUBFRAME_LSB +: 2] = own_sub;
      end
    end
    if (psel && penable && pwrite && paddr == csp_pkg::CTRL_OFFSET)
    begin
      next_s.bpf_reg = pwdata[csp_pkg::CTRL_BPF_LSB +: 2];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= RESET_STATE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign bit_clock_out = s.bclk;
  assign bit_clock_oe_n = s.clk_oe_n;
  assign frame_sync_pulse_out = s.fs;
  assign frame_sync_pulse_oe_n = s.clk_oe_n;
  assign serial_out_line = s.sout;
  assign serial_out_line_oe_n = s.sout_oe_n;
  assign gp_output_one = s.gpo[0];
  assign gp_output_one_oe_n = s.gpo_oe_n[0];
  assign multifunction_pin_five = s.gpo[1];
  assign multifunction_pin_five_oe_n = s.gpo_oe_n[1];
  assign dac_left = s.dac_l;
  assign dac_right = s.dac_r;
  assign control_field_a = s.ctl_a;
  assign control_field_b = s.ctl_b;
  assign analog_mute = s.mute;
  assign soft_power_down = s.soft_pd;
  assign calibrating = s.cal_cnt != 8'h00;
  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

endmodule

// ### rtl/csp_pkg.sv
package csp_pkg;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [1:0] CTRL_BPF_RESET = 2'h1;
  localparam int CTRL_BPF_LSB = 0;
  localparam int STATUS_ERR_LSB = 0;
  localparam int STATUS_SOFT_PD_BIT = 4;
  localparam int STATUS_CAL_BIT = 5;
  localparam int STATUS_MASTER_BIT = 6;
  localparam int STATUS_PWR_LSB = 8;
  localparam int STATUS_SUBFRAME_LSB = 12;
  localparam int CAL_FRAMES = 194;
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_CTRL_IGNORED = 4'h1;
  localparam logic [3:0] ERR_SOFT_PD = 4'h3;
  localparam logic [3:0] LOG_BPF_MIN = 4'h5;
  localparam logic [3:0] LOG_BPF_I2S = 4'h6;
  localparam logic [3:0] LOG_BPF_SPLIT_MAX = 4'h7;
  localparam logic [3:0] LOG_HALF_BIT_BASE = 4'h7;
  localparam logic [3:0] LOG_SLOW_BASE = 4'hA;
  localparam logic [7:0] SLOW_MULT_NUM = 8'h03;
  localparam logic [7:0] MULT_FACTOR = 8'h10;
  localparam int SUB_LOG_FULL = 6;
  localparam int SUB_LOG_SPLIT = 5;
  localparam int W_DAC_L = 48;
  localparam int W_CTL_A = 32;
  localparam int W_DAC_R = 16;
  localparam int W_CTL_IGNORE = 43;
  localparam int W_DO1 = 3;
  localparam int W_DO2 = 2;
  localparam int CTL_MUTE_BIT = 10;
  localparam logic [2:0] MODE_MULT = 3'h0;
  localparam logic [2:0] MODE_I2S = 3'h1;
  localparam logic [2:0] MODE_STD = 3'h2;
  localparam logic [2:0] MODE_TEST = 3'h3;
  typedef enum logic [1:0] {PWR_ON, PWR_DRAIN, PWR_OFF} csp_pwr_type;
endpackage

// ### sim/csp_checker_sva.sv
module csp_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic power_down_pin,
  input wire logic port_mode_sel_a,
  input wire logic port_mode_sel_b,
  input wire logic port_mode_sel_c,
  input wire logic master_select,
  input wire logic bit_clock_out,
  input wire logic bit_clock_oe_n,
  input wire logic frame_sync_pulse_out,
  input wire logic frame_sync_pulse_oe_n,
  input wire logic serial_out_line,
  input wire logic serial_out_line_oe_n,
  input wire logic gp_output_one_oe_n,
  input wire logic multifunction_pin_five_oe_n,
  input wire logic analog_mute,
  input wire logic soft_power_down,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata
);
  logic [2:0] mode;
  logic [9:0] gap;
  logic seen;
  assign mode = {port_mode_sel_c, port_mode_sel_b, port_mode_sel_a};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // The seen flag only holds while the port keeps mastering, so a stop never looks like a short frame.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap <= 10'h000;
      seen <= 1'b0;
    end
    else
    begin
      gap <= $rose(frame_sync_pulse_out) ? 10'h001 : gap + 10'h001;
      seen <= !frame_sync_pulse_oe_n && power_down_pin && (seen || $rose(frame_sync_pulse_out));
    end
  end
  sequence pd_held;
    !power_down_pin [*6];
  endsequence
  sequence std_master;
    (mode == 3'h2 && master_select && power_down_pin) [*2];
  endsequence
  sequence std_slave;
    (mode == 3'h2 && !master_select && power_down_pin) [*3];
  endsequence
  chk_pd_first_low: assert property ($fell(power_down_pin) |-> ##[1:4]
    (!serial_out_line_oe_n && !gp_output_one_oe_n && !serial_out_line)) else $error("no low drive");
  chk_pd_release: assert property (pd_held |-> serial_out_line_oe_n && gp_output_one_oe_n
    && multifunction_pin_five_oe_n && frame_sync_pulse_oe_n) else $error("pins not released");
  chk_softpd_mute: assert property (soft_power_down && $past(soft_power_down)
    |-> analog_mute) else $error("soft power-down not muted");
  chk_err_code: assert property (psel && penable && !pwrite && paddr == csp_pkg::STATUS_OFFSET
    && $past(soft_power_down) && $past(soft_power_down, 2)
    |-> prdata[3:0] == csp_pkg::ERR_SOFT_PD) else $error("error code wrong");
  chk_master_drive: assert property (std_master |-> !bit_clock_oe_n && !frame_sync_pulse_oe_n)
    else $error("master clocks not driven");
  chk_slave_float: assert property (std_slave |-> bit_clock_oe_n && frame_sync_pulse_oe_n)
    else $error("slave clocks driven");
  chk_i2s_master: assert property ((mode == 3'h1 && power_down_pin) [*2] |-> !bit_clock_oe_n)
    else $error("i2s not master");
  chk_sync_gap: assert property ($rose(frame_sync_pulse_out) && seen && mode inside {3'h1, 3'h2}
    |-> gap == 10'h100) else $error("frame length wrong");
  chk_mid_edge: assert property ($rose(frame_sync_pulse_out) && !frame_sync_pulse_oe_n
    |-> bit_clock_out == (mode != 3'h1)) else $error("bit clock phase wrong");
  chk_i2s_half: assert property ($rose(bit_clock_out) && mode == 3'h1 && seen
    |-> bit_clock_out [*2] ##1 !bit_clock_out [*2] ##1 bit_clock_out) else $error("bit period wrong");
endmodule
bind csp_serial_port csp_checker u_csp_checker (.clock, .rst_n, .power_down_pin, .port_mode_sel_a,
  .port_mode_sel_b, .port_mode_sel_c, .master_select, .bit_clock_out, .bit_clock_oe_n,
  .frame_sync_pulse_out, .frame_sync_pulse_oe_n, .serial_out_line, .serial_out_line_oe_n,
  .gp_output_one_oe_n, .multifunction_pin_five_oe_n, .analog_mute, .soft_power_down, .psel,
  .penable, .pwrite, .paddr, .prdata);

// ### sim/csp_host_model.sv
module csp_host_model (
  input wire logic clock,
  input wire logic serial_out_line,
  input wire logic serial_out_line_oe_n,
  output logic bit_clock_in,
  output logic frame_sync_pulse_in,
  output logic serial_in_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [127:0] rx;
  logic [127:0] hz;
  initial
  begin
    bit_clock_in = 1'b0;
    frame_sync_pulse_in = 1'b0;
    serial_in_line = 1'b0;
  end
  // Frames are sent back to back; the clock stands low after the last one and the
  // data line flips so that a stale level is never mistaken for a sample.
  task automatic frame(input logic [127:0] tx, input int nbits, input int half);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      @(posedge clock);
      bit_clock_in <= 1'b1;
      frame_sync_pulse_in <= (i == nbits - 1);
      serial_in_line <= tx[i];
      repeat (half) @(posedge clock);
      bit_clock_in <= 1'b0;
      // A released line floats, so it is shown inverted here.
      rx[i] <= serial_out_line_oe_n ? ~serial_out_line : serial_out_line;
      hz[i] <= serial_out_line_oe_n;
      repeat (half - 1) @(posedge clock);
    end
    serial_in_line <= ~tx[0];
  endtask
endmodule

// ### sim/codec_serial_port_control_bench.sv
module codec_serial_port_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic power_down_pin = 1'b1;
  logic port_mode_sel_a = 1'b0;
  logic port_mode_sel_b = 1'b1;
  logic port_mode_sel_c = 1'b0;
  logic subframe_sel_a = 1'b0;
  logic subframe_sel_b = 1'b0;
  logic master_select = 1'b0;
  logic gp_input_one = 1'b0;
  logic multifunction_pin_six = 1'b0;
  logic multifunction_pin_three = 1'b0;
  logic adc_clip_left = 1'b0;
  logic adc_clip_right = 1'b0;
  logic [15:0] adc_left = 16'h0000;
  logic [15:0] adc_right = 16'h0000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic bit_clock_in, frame_sync_pulse_in, serial_in_line, bit_clock_out, bit_clock_oe_n;
  logic frame_sync_pulse_out, frame_sync_pulse_oe_n, serial_out_line, serial_out_line_oe_n;
  logic gp_output_one, gp_output_one_oe_n, multifunction_pin_five, multifunction_pin_five_oe_n;
  logic [15:0] dac_left, dac_right, control_field_a, control_field_b;
  logic analog_mute, soft_power_down, calibrating, pready, pslverr;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic serr;
  logic [127:0] t;
  int errors = 0;
  int samples_checked = 0;
  int g;
  logic [4:0] tab [7] = '{5'h0A, 5'h04, 5'h11, 5'h02, 5'h09, 5'h12, 5'h0F};
  always #4 clock = ~clock;
  csp_serial_port #(.CAL_FRAMES(2)) u_csp_serial_port (.clock, .rst_n, .power_down_pin,
    .port_mode_sel_a, .port_mode_sel_b, .port_mode_sel_c, .subframe_sel_a, .subframe_sel_b,
    .master_select, .bit_clock_in, .bit_clock_out, .bit_clock_oe_n, .frame_sync_pulse_in,
    .frame_sync_pulse_out, .frame_sync_pulse_oe_n, .serial_in_line, .serial_out_line,
    .serial_out_line_oe_n, .gp_input_one, .multifunction_pin_six, .multifunction_pin_three,
    .gp_output_one, .gp_output_one_oe_n, .multifunction_pin_five, .multifunction_pin_five_oe_n,
    .adc_left, .adc_right, .adc_clip_left, .adc_clip_right, .dac_left, .dac_right,
    .control_field_a, .control_field_b, .analog_mute, .soft_power_down, .calibrating, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  csp_host_model u_csp_host_model (.clock, .serial_out_line, .serial_out_line_oe_n,
    .bit_clock_in, .frame_sync_pulse_in, .serial_in_line);
  task automatic end_of_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic do_reset(input logic [2:0] m, input logic ms);
    @(posedge clock);
    rst_n <= 1'b0;
    power_down_pin <= 1'b1;
    {port_mode_sel_c, port_mode_sel_b, port_mode_sel_a} <= m;
    master_select <= ms;
    repeat (16) @(posedge clock);
    check("reset_outs", 32'({serial_out_line, serial_out_line_oe_n, bit_clock_oe_n,
      frame_sync_pulse_out, gp_output_one, control_field_a, |dac_left}), 32'h0);
    rst_n <= 1'b1;
  endtask
  task automatic frames(input int nb, input int half, input int cnt, input int md);
    repeat (cnt)
    begin
      t = {$urandom, $urandom, $urandom, $urandom};
      t[43] = 1'b0;
      u_csp_host_model.frame(t, nb, half);
      if (md > 0)
      begin
        check("gp_out", t[3:2], {gp_output_one, multifunction_pin_five});
        check("err", md == 2 ? 3 : 0, u_csp_host_model.rx[39:36]);
        check("mute", md == 2 ? 1 : t[42], analog_mute);
        check("adc_valid", md == 1, u_csp_host_model.rx[42]);
      end
      if (md == 1)
      begin
        check("dac_left", t[63:48], dac_left);
        check("dac_right", t[31:16], dac_right);
        check("control", {t[47:32], t[15:0]}, {control_field_a, control_field_b});
        check("adc_left", adc_left, u_csp_host_model.rx[63:48]);
        check("adc_right", adc_right, u_csp_host_model.rx[31:16]);
        check("gp_in", {adc_clip_left, adc_clip_right, gp_input_one, multifunction_pin_six,
          multifunction_pin_three}, {u_csp_host_model.rx[41:40], u_csp_host_model.rx[3:1]});
      end
    end
  endtask
  task automatic fs_gap(output int gv);
    int n;
    int s;
    n = 0;
    s = 0;
    for (int k = 0; k < 2; k++)
    begin
      s = n;
      while (frame_sync_pulse_out === 1'b1 && n < 3000) begin @(posedge clock); n++; end
      while (frame_sync_pulse_out !== 1'b1 && n < 3000) begin @(posedge clock); n++; end
    end
    gv = n - s;
    if (n >= 3000)
    begin
      errors++;
      end_of_test();
    end
  endtask
  initial
  begin
    void'($urandom(32'h57C366C6));
    do_reset(3'h2, 1'b0);
    apb(1'b0, csp_pkg::CTRL_OFFSET, 32'h0);
    check("ctrl", 32'(csp_pkg::CTRL_BPF_RESET), rd);
    apb(1'b0, csp_pkg::STATUS_OFFSET, 32'h0);
    check("cal", 1, rd[csp_pkg::STATUS_CAL_BIT]);
    apb(1'b0, 8'h08, 32'h0);
    check("unmapped_rd", 0, rd);
    check("unmapped_err", 1, serr);
    @(posedge clock);
    {adc_left, adc_right} <= $urandom;
    {adc_clip_left, adc_clip_right, gp_input_one, multifunction_pin_six} <= 4'($urandom);
    multifunction_pin_three <= 1'b1;
    frames(64, 5, 5, 0);
    frames(64, 5, 3, 1);
    check("cal_done", 0, calibrating);
    apb(1'b1, csp_pkg::CTRL_OFFSET, 32'h2);
    subframe_sel_a <= 1'b1;
    frames(128, 5, 2, 0);
    check("cal_restart", 1, calibrating);
    frames(128, 5, 3, 0);
    frames(128, 5, 2, 1);
    check("own_slot", 2, {&u_csp_host_model.hz[127:64], |u_csp_host_model.hz[63:0]});
    frames(128, 13, 1, 0);
    frames(128, 13, 1, 2);
    check("soft_pd", 1, soft_power_down);
    apb(1'b0, csp_pkg::STATUS_OFFSET, 32'h0);
    check("status_err", csp_pkg::ERR_SOFT_PD, rd[3:0]);
    apb(1'b1, csp_pkg::CTRL_OFFSET, 32'h1);
    subframe_sel_a <= 1'b0;
    frames(64, 13, 3, 0);
    check("soft_pd_exit", 0, soft_power_down);
    power_down_pin <= 1'b0;
    repeat (8) @(posedge clock);
    check("pd_release", 15, {serial_out_line_oe_n, gp_output_one_oe_n,
      multifunction_pin_five_oe_n, frame_sync_pulse_oe_n});
    foreach (tab[k])
    begin
      do_reset(tab[k][4:2], tab[k][1]);
      repeat (20) @(posedge clock);
      check("clock_oe_n", tab[k][0], bit_clock_oe_n);
      if (!tab[k][0] && tab[k][4:2] inside {3'h1, 3'h2})
      begin
        fs_gap(g);
        check("frame_gap", 256, g);
      end
    end
    end_of_test();
  end
endmodule
